// [hdl/spl_top.v]
`timescale 1ns/10ps
`include "spl_defines.vh"
// start-up parameter loader with apb register slave
module spl_top (
  input wire clock,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire card_present,
  input wire swap_detected,
  input wire failsafe_unit,
  input wire image_found,
  input wire copy_done,
  input wire copy_ok,
  input wire [15:0] reject_param,
  input wire swap_done,
  input wire digital_confirm,
  input wire plc_confirm,
  output reg copy_req,
  output reg copy_from_card,
  output reg swap_req,
  output reg startup_done,
  output reg [15:0] fault_code,
  output reg irq
);
  localparam S_BOOT = 3'd0;
  localparam S_CHECK = 3'd1;
  localparam S_SWAP = 3'd2;
  localparam S_EEPROM = 3'd3;
  localparam S_CARD = 3'd4;
  localparam S_RESTORE = 3'd5;
  localparam S_DONE = 3'd6;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // download mode survives rst_n, like a stored setting
  reg [1:0] mode_r = `SPL_MODE_RESET;
  reg [1:0] src_r;
  reg [7:0] stage_r;
  reg failsafe_r;
  reg swap_path_r;
  reg card_path_r;
  reg pend_r;
  reg f61_r;
  reg f63_r;
  reg [15:0] reject_r;
  reg [`SPL_IRQ_W-1:0] mask_r;
  reg confirm_in_d_r;
  wire [`SPL_IRQ_W-1:0] irq_stat;
  reg [`SPL_IRQ_W-1:0] irq_set;
  reg [`SPL_IRQ_W-1:0] irq_clr;

  // apb decode: write commits on the edge where pready is high
  wire apb_acc = psel & penable;
  wire apb_fire = apb_acc & pready;
  wire wr_fire = apb_fire & pwrite;
  wire wr_ctrl = wr_fire & (paddr == `SPL_ADDR_CTRL);
  wire wr_confirm = wr_fire & (paddr == `SPL_ADDR_CONFIRM);
  wire wr_stage = wr_fire & (paddr == `SPL_ADDR_STAGE);
  wire wr_pw = wr_fire & (paddr == `SPL_ADDR_PASSWORD);
  wire wr_istat = wr_fire & (paddr == `SPL_ADDR_IRQ_STAT);
  wire wr_imask = wr_fire & (paddr == `SPL_ADDR_IRQ_MASK);
  wire fs_accept;

  // routed operator/plc confirm, rising edge
  reg confirm_in;
  always @* begin
    case (src_r)
      `SPL_SRC_DIGITAL: confirm_in = digital_confirm;
      `SPL_SRC_PLC: confirm_in = plc_confirm;
      default: confirm_in = 1'b0;
    endcase
  end
  wire confirm_edge = confirm_in & ~confirm_in_d_r;

  // clears of the pending download fault for each unit kind
  wire std_clear = ~failsafe_r &
    ((wr_confirm & (pwdata == `SPL_CONFIRM_ZERO)) | confirm_edge);
  wire fs_clear = failsafe_r & fs_accept;
  wire pend_clear = pend_r & (std_clear | fs_clear);

  // whether this start-up should download from the card
  wire want_card = card_present & image_found |
    card_present & ~image_found;
  wire mode_dl = (mode_r == `SPL_MODE_ONCE) | (mode_r == `SPL_MODE_ALWAYS);

  // start-up sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_BOOT: state_nxt = S_CHECK;
      S_CHECK: begin
        if (swap_detected)
          state_nxt = S_SWAP;
        else if (card_present && mode_dl && want_card)
          state_nxt = image_found ? S_CARD : S_RESTORE;
        else
          state_nxt = S_EEPROM;
      end
      S_SWAP: begin
        if (swap_done)
          state_nxt = S_DONE;
      end
      S_EEPROM: begin
        if (copy_done)
          state_nxt = S_DONE;
      end
      S_CARD: begin
        if (copy_done)
          state_nxt = copy_ok ? S_DONE : S_RESTORE;
      end
      S_RESTORE: begin
        if (copy_done)
          state_nxt = S_DONE;
      end
      S_DONE: state_nxt = S_DONE;
      default: state_nxt = S_BOOT;
    endcase
  end

  // sequencer state and copy/swap requests
  always @(posedge clock) begin
    if (!rst_n) begin
      state_r <= S_BOOT;
      copy_req <= 1'b0;
      copy_from_card <= 1'b0;
      swap_req <= 1'b0;
      swap_path_r <= 1'b0;
      card_path_r <= 1'b0;
      failsafe_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (state_r == S_BOOT)
        failsafe_r <= failsafe_unit;
      if (state_r == S_CHECK) begin
        card_path_r <= card_present;
        swap_path_r <= swap_detected;
      end
      swap_req <= (state_nxt == S_SWAP);
      copy_req <= (state_nxt == S_EEPROM) | (state_nxt == S_CARD) |
        (state_nxt == S_RESTORE);
      copy_from_card <= (state_nxt == S_CARD);
    end
  end

  // download faults latch until reset, pending confirm fault
  always @(posedge clock) begin
    if (!rst_n) begin
      f61_r <= 1'b0;
      f63_r <= 1'b0;
      pend_r <= 1'b0;
      reject_r <= 16'h0000;
    end else if (ce) begin
      if (state_r == S_CHECK && state_nxt == S_RESTORE)
        f61_r <= 1'b1;
      if (state_r == S_CARD && copy_done && !copy_ok) begin
        f63_r <= 1'b1;
        reject_r <= reject_param;
      end
      if (state_r == S_CARD && copy_done && copy_ok)
        pend_r <= 1'b1;
      else if (pend_clear)
        pend_r <= 1'b0;
      if (state_r == S_CARD && copy_done && copy_ok &&
          mode_r == `SPL_MODE_ONCE)
        mode_r <= `SPL_MODE_NONE;
      else if (wr_ctrl)
        mode_r <= pwdata[`SPL_CTRL_MODE_LSB +: 2];
    end
  end

  // software settings and routed input history
  always @(posedge clock) begin
    if (!rst_n) begin
      src_r <= `SPL_SRC_RESET;
      stage_r <= `SPL_STAGE_RESET;
      mask_r <= {`SPL_IRQ_W{1'b0}};
      confirm_in_d_r <= 1'b0;
    end else if (ce) begin
      confirm_in_d_r <= confirm_in;
      if (wr_ctrl)
        src_r <= pwdata[`SPL_CTRL_SRC_LSB +: 2];
      if (wr_stage)
        stage_r <= pwdata[7:0];
      if (wr_imask)
        mask_r <= pwdata[`SPL_IRQ_W-1:0];
    end
  end

  // done flag and visible fault code; latched faults take priority
  always @(posedge clock) begin
    if (!rst_n) begin
      startup_done <= 1'b0;
      fault_code <= `SPL_FAULT_NONE;
    end else if (ce) begin
      startup_done <= (state_r == S_DONE);
      if (f63_r)
        fault_code <= `SPL_FAULT_F0063;
      else if (f61_r)
        fault_code <= `SPL_FAULT_F0061;
      else if (pend_r)
        fault_code <= `SPL_FAULT_F0395;
      else
        fault_code <= `SPL_FAULT_NONE;
    end
  end

  // interrupt events
  always @* begin
    irq_set = {`SPL_IRQ_W{1'b0}};
    irq_set[`SPL_IRQ_DONE] = (state_r != S_DONE) & (state_nxt == S_DONE);
    irq_set[`SPL_IRQ_F0395] = (state_r == S_CARD) & copy_done & copy_ok;
    irq_set[`SPL_IRQ_FAIL] = (state_nxt == S_RESTORE) &
      (state_r != S_RESTORE);
    irq_set[`SPL_IRQ_CONFIRM] = pend_clear;
    irq_clr = wr_istat ? pwdata[`SPL_IRQ_W-1:0] : {`SPL_IRQ_W{1'b0}};
  end

  spl_sticky #(
    .W(`SPL_IRQ_W)
  ) u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_stat)
  );

  spl_accept_seq u_accept (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .stage_wr(wr_stage),
    .stage_val(pwdata[7:0]),
    .pw_wr(wr_pw),
    .pw_val(pwdata),
    .confirm_wr(wr_confirm),
    .confirm_val(pwdata),
    .accept(fs_accept)
  );

  // read mux
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SPL_ADDR_CTRL: begin
        rd_val[`SPL_CTRL_MODE_LSB +: 2] = mode_r;
        rd_val[`SPL_CTRL_SRC_LSB +: 2] = src_r;
      end
      `SPL_ADDR_STATUS: begin
        rd_val[`SPL_ST_DONE] = startup_done;
        rd_val[`SPL_ST_SWAP] = swap_path_r;
        rd_val[`SPL_ST_CARD] = card_path_r;
        rd_val[`SPL_ST_PEND] = pend_r;
        rd_val[`SPL_ST_F61] = f61_r;
        rd_val[`SPL_ST_F63] = f63_r;
        rd_val[`SPL_ST_FAILSAFE] = failsafe_r;
      end
      `SPL_ADDR_FAULT: rd_val[15:0] = fault_code;
      `SPL_ADDR_REJECT: rd_val[15:0] = reject_r;
      `SPL_ADDR_CONFIRM: rd_val[0] = pend_r;
      `SPL_ADDR_STAGE: rd_val[7:0] = stage_r;
      `SPL_ADDR_PASSWORD: rd_val = 32'h0000_0000; // write only
      `SPL_ADDR_IRQ_STAT: rd_val[`SPL_IRQ_W-1:0] = irq_stat;
      `SPL_ADDR_IRQ_MASK: rd_val[`SPL_IRQ_W-1:0] = mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer one cycle into the access phase, and irq line
  always @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat & mask_r);
      if (apb_acc && !pready) begin
        pready <= 1'b1;
        pslverr <= ~rd_hit;
        prdata <= (pwrite | ~rd_hit) ? 32'h0000_0000 : rd_val;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule // spl_top

// [hdl/spl_defines.vh]
// What this block does
// - at each start-up, sample the card-present input before choosing a path
// - a replaced control unit or power module selects the swap path
// - normal start-up without card copies eeprom parameters into ram
// - mode 0: never download from the card at start-up
// - mode 1 (default): download once, rewrite mode to 0 after a successful card copy
// - mode 2: download at every start-up with a card, mode kept
// - mode 1 or 2 without card: eeprom set, no alarm, no fault
// - download reads the fixed default image; missing image gives F0061
// - successful download raises F0395, held until confirmed or accepted
// - standard unit: routed digital/plc confirm or writing 0 clears F0395
// - fail-safe unit: stage 30, password, then write 0 clears F0395
// - failed download restores eeprom set and raises F0061 or F0063
// - rejected parameter gives F0063 and records first rejected number
// - F0061/F0063 from start-up stay latched until power cycle
`ifndef SPL_DEFINES_VH
`define SPL_DEFINES_VH

// register byte addresses
`define SPL_ADDR_CTRL 8'h00
`define SPL_ADDR_STATUS 8'h04
`define SPL_ADDR_FAULT 8'h08
`define SPL_ADDR_REJECT 8'h0C
`define SPL_ADDR_CONFIRM 8'h10
`define SPL_ADDR_STAGE 8'h14
`define SPL_ADDR_PASSWORD 8'h18
`define SPL_ADDR_IRQ_STAT 8'h1C
`define SPL_ADDR_IRQ_MASK 8'h20

// ctrl fields
`define SPL_CTRL_MODE_LSB 0
`define SPL_CTRL_SRC_LSB 2
`define SPL_MODE_NONE 2'h0
`define SPL_MODE_ONCE 2'h1
`define SPL_MODE_ALWAYS 2'h2
`define SPL_MODE_RESET 2'h1
`define SPL_SRC_NONE 2'h0
`define SPL_SRC_DIGITAL 2'h1
`define SPL_SRC_PLC 2'h2
`define SPL_SRC_RESET 2'h1

// status fields
`define SPL_ST_DONE 0
`define SPL_ST_SWAP 1
`define SPL_ST_CARD 2
`define SPL_ST_PEND 3
`define SPL_ST_F61 4
`define SPL_ST_F63 5
`define SPL_ST_FAILSAFE 6

// fault codes as numbers
`define SPL_FAULT_NONE 16'h0000
`define SPL_FAULT_F0061 16'h0061
`define SPL_FAULT_F0063 16'h0063
`define SPL_FAULT_F0395 16'h0395

// irq bits
`define SPL_IRQ_W 4
`define SPL_IRQ_DONE 0
`define SPL_IRQ_F0395 1
`define SPL_IRQ_FAIL 2
`define SPL_IRQ_CONFIRM 3

// fail-safe acceptance
`define SPL_STAGE_ACCEPT 8'h1E
`define SPL_PASSWORD_VAL 32'h0000_0000
`define SPL_STAGE_RESET 8'h00
`define SPL_CONFIRM_ZERO 32'h0000_0000

`endif

// [hdl/spl_sticky.v]
`timescale 1ns/10ps
// sticky event bits, set beats write-one-to-clear
module spl_sticky #(
  parameter W = 4
) (
  input wire clock,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] q
);
  // hold, set or clear each bit
  always @(posedge clock) begin
    if (!rst_n) begin
      q <= {W{1'b0}};
    end else if (ce) begin
      q <= set | (q & ~clr);
    end
  end
endmodule // spl_sticky

// [hdl/spl_accept_seq.v]
`timescale 1ns/10ps
`include "spl_defines.vh"
// fail-safe acceptance order: stage 30, password, then confirm 0
module spl_accept_seq (
  input wire clock,
  input wire rst_n,
  input wire ce,
  input wire stage_wr,
  input wire [7:0] stage_val,
  input wire pw_wr,
  input wire [31:0] pw_val,
  input wire confirm_wr,
  input wire [31:0] confirm_val,
  output reg accept
);
  localparam S_WAIT_STAGE = 2'd0;
  localparam S_WAIT_PW = 2'd1;
  localparam S_WAIT_CLR = 2'd2;
  reg [1:0] step_r;
  reg [1:0] step_nxt;
  reg accept_nxt;

  // next step; a write out of order starts over
  always @* begin
    step_nxt = step_r;
    accept_nxt = 1'b0;
    case (step_r)
      S_WAIT_STAGE: begin
        if (stage_wr && stage_val == `SPL_STAGE_ACCEPT)
          step_nxt = S_WAIT_PW;
      end
      S_WAIT_PW: begin
        if (pw_wr && pw_val == `SPL_PASSWORD_VAL)
          step_nxt = S_WAIT_CLR;
        else if (pw_wr || confirm_wr)
          step_nxt = S_WAIT_STAGE;
        else if (stage_wr && stage_val != `SPL_STAGE_ACCEPT)
          step_nxt = S_WAIT_STAGE;
      end
      S_WAIT_CLR: begin
        if (confirm_wr) begin
          step_nxt = S_WAIT_STAGE;
          accept_nxt = (confirm_val == `SPL_CONFIRM_ZERO);
        end else if (stage_wr || pw_wr) begin
          step_nxt = S_WAIT_STAGE;
        end
      end
      default: step_nxt = S_WAIT_STAGE;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      step_r <= S_WAIT_STAGE;
      accept <= 1'b0;
    end else if (ce) begin
      step_r <= step_nxt;
      accept <= accept_nxt;
    end
  end
endmodule // spl_accept_seq

// [sim/spl_assertions.sv]
`timescale 1ns/10ps
// port checks for the start-up loader
module spl_assertions (
  input wire clock,
  input wire rst_n,
  input wire pwrite,
  input wire pready,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire failsafe_unit,
  input wire card_present,
  input wire image_found,
  input wire copy_done,
  input wire copy_ok,
  input wire copy_req,
  input wire copy_from_card,
  input wire swap_req,
  input wire startup_done,
  input wire [15:0] fault_code
);
  // single domain, reset stands every check down
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // download mode as the bus and the card path leave it; not reset
  reg [1:0] mode_m = 2'h1;
  wire card_dl = (mode_m == 2'h1) || (mode_m == 2'h2);
  always @(posedge clock) begin
    if (copy_req && copy_from_card && copy_done && copy_ok &&
        mode_m == 2'h1)
      mode_m <= 2'h0;
    else if (pready && pwrite && paddr == 8'h00)
      mode_m <= pwdata[1:0];
  end
  // path chosen only after the check state
  property p_pick;
    $rose(rst_n) |=> !copy_req ##[1:3] (copy_req || swap_req);
  endproperty
  a_pick: assert property (p_pick)
    else $error("start-up path timing wrong");
  property p_swap; swap_req |-> !copy_req; endproperty
  a_swap: assert property (p_swap)
    else $error("copy during swap path");
  property p_once;
    $rose(copy_req) && card_present && image_found && card_dl
      |-> copy_from_card;
  endproperty
  a_once: assert property (p_once)
    else $error("download mode did not load from card");
  property p_nodl;
    $rose(copy_req) && !card_dl |-> !copy_from_card;
  endproperty
  a_nodl: assert property (p_nodl)
    else $error("card load while downloads are off");
  property p_noimg;
    $rose(copy_req) && card_present && !image_found |-> !copy_from_card;
  endproperty
  a_noimg: assert property (p_noimg)
    else $error("card copy without image");
  property p_nocard;
    startup_done && !card_present |-> fault_code == 16'h0000;
  endproperty
  a_nocard: assert property (p_nocard)
    else $error("fault without card");
  property p_conf;
    pready && pwrite && paddr == 8'h10 && pwdata == 32'h0000_0000 &&
      !failsafe_unit && fault_code == 16'h0395
      |-> ##[1:3] fault_code == 16'h0000;
  endproperty
  a_conf: assert property (p_conf)
    else $error("confirm write did not clear");
  property p_rest;
    copy_req && copy_from_card && copy_done && !copy_ok
      |-> ##[1:2] copy_req && !copy_from_card;
  endproperty
  a_rest: assert property (p_rest)
    else $error("no restore after failed copy");
  property p_latch;
    fault_code == 16'h0061 || fault_code == 16'h0063 |=> $stable(fault_code);
  endproperty
  a_latch: assert property (p_latch)
    else $error("download fault cleared");
  property p_done;
    $rose(startup_done) |-> !copy_req && !swap_req && !$past(copy_req);
  endproperty
  a_done: assert property (p_done)
    else $error("done before load finished");
endmodule // spl_assertions

// [sim/spl_partner.sv]
`timescale 1ns/10ps
// copy engine standing for card and eeprom
module spl_partner #(
  parameter [15:0] REJ = 16'h0123
) (
  input wire clock,
  input wire rst_n,
  input wire copy_req,
  input wire copy_from_card,
  input wire fail_card,
  input wire slow,
  output reg copy_done,
  output reg copy_ok,
  output wire [15:0] reject_param
);
  reg [3:0] cnt_r;
  reg busy_r;
  reg src_r;
  // number valid only beside a failed copy
  assign reject_param = (copy_done && !copy_ok) ? REJ : ~REJ;
  // one copy per request or per change of source
  always @(posedge clock) begin
    copy_done <= 1'b0;
    copy_ok <= ~copy_ok; // meaningless outside done
    if (!rst_n || !copy_req) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      copy_ok <= 1'b0;
    end else if (busy_r) begin
      if (copy_from_card != src_r) busy_r <= 1'b0; // restore follows
    end else if (cnt_r == (slow ? 4'h9 : 4'h2)) begin
      copy_done <= 1'b1;
      copy_ok <= !(copy_from_card && fail_card);
      busy_r <= 1'b1;
      src_r <= copy_from_card;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // spl_partner

// [sim/test_startup_parameter_loader.sv]
`timescale 1ns/10ps
`include "spl_defines.vh"
// start-up loader bench: power-ups and register traffic
module test_startup_parameter_loader;
  reg clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, card_present = 1'b0, swap_detected = 1'b0;
  reg failsafe_unit = 1'b0, image_found = 1'b0, swap_done = 1'b0;
  reg digital_confirm = 1'b0, plc_confirm = 1'b0, fail = 1'b0;
  reg slow = 1'b0, cr_q = 1'b0, ce = 1'b1, src_seen, swap_seen, rerr;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000, rdat;
  wire [31:0] prdata;
  wire [15:0] fault_code, reject_param;
  wire pready, pslverr, copy_done, copy_ok, copy_req, copy_from_card;
  wire swap_req, startup_done, irq;
  integer error_cnt = 0, total_checks = 0;

  spl_top uut (.clock, .rst_n, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .card_present,
    .swap_detected, .failsafe_unit, .image_found, .copy_done, .copy_ok,
    .reject_param, .swap_done, .digital_confirm, .plc_confirm, .copy_req,
    .copy_from_card, .swap_req, .startup_done, .fault_code, .irq);
  spl_partner mem (.clock, .rst_n, .copy_req, .copy_from_card,
    .fail_card(fail), .slow, .copy_done, .copy_ok, .reject_param);

  // clock, 4 ns period
  initial forever #2 clock = ~clock;

  // source of the first copy and any swap request per start-up
  always @(posedge clock) begin
    cr_q <= copy_req;
    if (copy_req && !cr_q) src_seen <= copy_from_card;
    swap_seen <= rst_n && (swap_seen || swap_req);
  end

  task close_out;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  task chk16(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  task chkb(input g, input e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask

  // apb transfer, waits for pready under a bound
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chkb(pready, 1'b1);
      if (pready !== 1'b1) close_out;
    end
  endtask

  // power cycle with given straps, then wait for start-up done
  task boot(input c, input s, input i, input f, input k, input l);
    integer n;
    begin
      @(posedge clock);
      rst_n <= 1'b0;
      card_present <= c;
      swap_detected <= s;
      swap_done <= s;
      image_found <= i;
      failsafe_unit <= f;
      fail <= k;
      slow <= l;
      digital_confirm <= 1'b0;
      plc_confirm <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      n = 0;
      while (startup_done !== 1'b1 && n < 100) begin
        @(posedge clock);
        n = n + 1;
      end
      chkb(startup_done, 1'b1);
      if (startup_done !== 1'b1) close_out;
    end
  endtask

  initial begin
    // no card: eeprom set, no fault
    boot(0, 0, 1, 0, 0, 0);
    chkb(src_seen, 1'b0);
    chk16(fault_code, `SPL_FAULT_NONE);
    apb(0, `SPL_ADDR_CTRL, 32'h0000_0000);
    chk16(rdat[15:0], 16'h0005);
    // card with image: one download, irq, confirm by write
    boot(1, 0, 1, 0, 0, 1);
    chkb(src_seen, 1'b1);
    apb(0, `SPL_ADDR_CTRL, 32'h0000_0000);
    chk16(rdat[15:0], 16'h0004);
    chkb(irq, 1'b0);
    apb(1, `SPL_ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(posedge clock);
    chkb(irq, 1'b1);
    chk16(fault_code, `SPL_FAULT_F0395);
    apb(1, `SPL_ADDR_CONFIRM, 32'h0000_0000);
    repeat (3) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_NONE);
    apb(0, `SPL_ADDR_IRQ_STAT, 32'h0000_0000);
    chk16(rdat[15:0], 16'h000B);
    apb(1, `SPL_ADDR_IRQ_STAT, 32'h0000_000F);
    repeat (3) @(posedge clock);
    chkb(irq, 1'b0);
    apb(0, 8'h24, 32'h0000_0000);
    chkb(rerr, 1'b1);
    // mode rewritten to 0: card ignored at the next start-up
    boot(1, 0, 1, 0, 0, 0);
    chkb(src_seen, 1'b0);
    chk16(fault_code, `SPL_FAULT_NONE);
    apb(1, `SPL_ADDR_CTRL, 32'h0000_0002);
    // mode 2 loads and stays; only the selected source confirms
    boot(1, 0, 1, 0, 0, 0);
    chkb(src_seen, 1'b1);
    apb(0, `SPL_ADDR_CTRL, 32'h0000_0000);
    chk16(rdat[15:0], 16'h0006);
    apb(1, `SPL_ADDR_CTRL, 32'h0000_000A);
    digital_confirm <= 1'b1;
    repeat (4) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_F0395);
    // frozen by the clock enable, the edge counts once it runs again
    ce <= 1'b0;
    plc_confirm <= 1'b1;
    repeat (4) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_F0395);
    ce <= 1'b1;
    repeat (4) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_NONE);
    // missing image: restore, fault ignores clearing
    boot(1, 0, 0, 0, 0, 0);
    chkb(src_seen, 1'b0);
    apb(0, `SPL_ADDR_IRQ_STAT, 32'h0000_0000);
    chk16(rdat[15:0], 16'h0005);
    apb(1, `SPL_ADDR_CONFIRM, 32'h0000_0000);
    repeat (3) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_F0061);
    // rejected parameter during a slow card copy
    boot(1, 0, 1, 0, 1, 1);
    chk16(fault_code, `SPL_FAULT_F0063);
    apb(0, `SPL_ADDR_REJECT, 32'h0000_0000);
    chk16(rdat[15:0], 16'h0123);
    // replaced unit takes the swap path
    boot(0, 1, 1, 0, 0, 0);
    chkb(swap_seen, 1'b1);
    // fail-safe unit: confirm alone is not enough
    boot(1, 0, 1, 1, 0, 0);
    apb(0, `SPL_ADDR_STATUS, 32'h0000_0000);
    chk16(rdat[15:0], 16'h004D);
    apb(1, `SPL_ADDR_CONFIRM, 32'h0000_0000);
    repeat (4) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_F0395);
    apb(1, `SPL_ADDR_STAGE, 32'h0000_001E);
    apb(1, `SPL_ADDR_PASSWORD, `SPL_PASSWORD_VAL);
    apb(1, `SPL_ADDR_CONFIRM, 32'h0000_0000);
    repeat (4) @(posedge clock);
    chk16(fault_code, `SPL_FAULT_NONE);
    close_out;
  end
endmodule // test_startup_parameter_loader

bind spl_top spl_assertions chk (.clock, .rst_n, .pwrite, .pready, .paddr,
  .pwdata, .failsafe_unit, .card_present, .image_found, .copy_done,
  .copy_ok, .copy_req, .copy_from_card, .swap_req, .startup_done,
  .fault_code);
